// ---- rtl/pwr_ctrl_pkg.sv ----
// Overview of operation
// (R1) Clock select high: system runs from RTC, RC oscillator off; low: RC.
// (R2) Power-down stops the system clock regardless of select; RTC keeps running.
// (R3) Power-up clears the RTC quick-start bit, bit 1 of control zero.
// (R4) Software should set the quick-start bit about two seconds after power-on.
// (R5) RTC runs normally whatever the quick-start bit holds.
// (R6) Watchdog oscillator free-runs in power-down unless option disables it.
// (R7) Power-down is entered only by the halt instruction.
// (R8) Memory, registers and ports hold their values while powered down.
// (R9) Halt clears the watchdog; it keeps counting unless clocked by system clock.
// (R10) Halt sets the power-down flag and clears the time-out flag.
// (R11) Any analog-configured pin keeps the A/D converter powered.
// (R12) Wake on reset, port-A 0..6 falling edge, interrupt or watchdog overflow.
// (R13) Reset wake gives full reset; watchdog wake gives watchdog reset.
// (R14) Power-down flag cleared by power-up or watchdog clear, set by halt.
// (R15) Watchdog time-out in power-down sets time-out, resets only PC and SP.
// (R16) Each port-A line 0..6 enabled to wake on fall; resume after halt.
// (R17) Disabled or stack-full interrupt wake resumes after halt, stays pending.
// (R18) Enabled interrupt with free stack wake takes normal interrupt response.
// (R19) Interrupt already requested before halt cannot wake the device.
// (R20) Wake waits 1024 system clocks; resume after halt runs at once then.
// (R21) Interrupt wake delays service entry at least one more cycle.
// (R22) Restart counter counts after oscillator restarts; reset on each entry.
package pwr_ctrl_pkg;
    localparam int          WAKE_LINES      = 7;
    localparam int          RESTART_CYCLES  = 1024;
    localparam int          CNT_W           = 11;
    localparam int          QSTART_BIT      = 1;
    localparam int          CLKSEL_BIT      = 0;
    localparam logic [7:0]  CONTROL_REGISTER_ZERO_RESET     = 8'h00;
    localparam logic [7:0]  CONTROL_REGISTER_ZERO_MASK      = 8'h6f;
    localparam logic [3:0]  AN_NONE         = 4'h0;
    // Bus offsets of the control and status words
    localparam logic [3:0]  OFF_CONTROL_REGISTER_ZERO       = 4'h0;
    localparam logic [3:0]  OFF_WAKE_EN     = 4'h4;
    localparam logic [3:0]  OFF_ADC_CFG     = 4'h8;
    localparam logic [3:0]  OFF_STATUS      = 4'hc;
endpackage

// ---- rtl/power_down_wakeup_clock_select.sv ----
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module power_down_wakeup_clock_select #(
    parameter bit WDT_OSC_ENABLE = 1'b1,
    parameter bit WDT_FROM_SYS   = 1'b0
) (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Core side
    input  wire logic        halt_exec_i,
    input  wire logic        wdt_clear_i,
    input  wire logic        ext_reset_i,
    input  wire logic        wdt_overflow_i,
    input  wire logic        irq_req_i,
    input  wire logic        irq_enabled_i,
    input  wire logic        stack_full_i,
    input  wire logic [6:0]  port_a_i,
    input  wire logic        osc_ready_i,
    // Controls
    output logic             rc_osc_en_o,
    output logic             rtc_osc_en_o,
    output logic             rtc_quick_o,
    output logic             sysclk_rtc_o,
    output logic             sysclk_run_o,
    output logic             wdt_osc_en_o,
    output logic             wdt_clear_o,
    output logic             wdt_run_o,
    output logic             adc_power_o,
    output logic             hold_state_o,
    output logic             core_run_o,
    output logic             full_reset_o,
    output logic             pc_sp_reset_o,
    output logic             irq_service_o,
    output logic             powerdown_flag_o,
    output logic             watchdog_timeout_flag_o
);
    localparam int CNT_W_L = pwr_ctrl_pkg::CNT_W;

    typedef enum logic [1:0] {RUN, SLEEP, RESTART, IRQ_GAP} mode_t;

    typedef struct packed {
        mode_t                 mode;
        logic [7:0]            ctrl;
        logic [6:0]            wake_en;
        logic [3:0]            adc_cfg;
        logic                  powerdown_flag;
        logic                  tof;
        logic [CNT_W_L-1:0]    cnt;
        logic [1:0]            why;
        logic                  irq_block;
        logic [6:0]            pa_s1;
        logic [6:0]            pa_s2;
        logic [6:0]            pa_old;
        logic                  rd_done;
        logic [31:0]           rdata;
        logic                  wclr;
        logic                  full_rst;
        logic                  pcsp_rst;
        logic                  irq_go;
    } state_t;

    localparam logic [1:0] WHY_RESUME = 2'd0;
    localparam logic [1:0] WHY_IRQ    = 2'd1;
    localparam logic [1:0] WHY_WDT    = 2'd2;
    localparam logic [CNT_W_L-1:0] LAST =
        CNT_W_L'(pwr_ctrl_pkg::RESTART_CYCLES - 1);

    // One decode shared by reads and writes keeps the map in one place
    function automatic logic [3:0] decode_hit(input logic [3:0] adr);
        logic [3:0] hit;
        hit = 4'h0;
        if (adr == pwr_ctrl_pkg::OFF_CONTROL_REGISTER_ZERO) begin
            hit[0] = 1'b1;
        end else if (adr == pwr_ctrl_pkg::OFF_WAKE_EN) begin
            hit[1] = 1'b1;
        end else if (adr == pwr_ctrl_pkg::OFF_ADC_CFG) begin
            hit[2] = 1'b1;
        end else if (adr == pwr_ctrl_pkg::OFF_STATUS) begin
            hit[3] = 1'b1;
        end
        return hit;
    endfunction

    state_t s_r;
    state_t s_nxt;
    logic   pin_fall;
    logic   irq_wake;
    logic   [3:0] reg_hit;

    // Register select, one bit per mapped word
    assign reg_hit = decode_hit(avs_address_i);
    // Falling edge on enabled port-A lines, from synchronised copies only
    assign pin_fall = |(s_r.pa_old & ~s_r.pa_s2 & s_r.wake_en); // [R16]
    // Requests already present at halt are masked until they drop
    assign irq_wake = irq_req_i & ~s_r.irq_block; // [R19]

    // Next-state logic for mode, flags and bus
    always_comb begin
        s_nxt          = s_r;
        s_nxt.pa_s1    = port_a_i;
        s_nxt.pa_s2    = s_r.pa_s1;
        s_nxt.pa_old   = s_r.pa_s2;
        s_nxt.wclr     = 1'b0;
        s_nxt.full_rst = 1'b0;
        s_nxt.pcsp_rst = 1'b0;
        s_nxt.irq_go   = 1'b0;
        s_nxt.rd_done  = 1'b0;
        if (!irq_req_i) begin
            s_nxt.irq_block = 1'b0;
        end
        // Single-cycle wait: reads answer on the edge after the request
        if (avs_read_i && !s_r.rd_done) begin
            s_nxt.rd_done = 1'b1;
            if (reg_hit[0]) begin
                s_nxt.rdata = {24'h00_0000, s_r.ctrl};
            end else if (reg_hit[1]) begin
                s_nxt.rdata = {25'h000_0000, s_r.wake_en};
            end else if (reg_hit[2]) begin
                s_nxt.rdata = {28'h000_0000, s_r.adc_cfg};
            end else if (reg_hit[3]) begin
                s_nxt.rdata = {28'h000_0000, s_r.mode != RUN,
                               1'b0, s_r.tof, s_r.powerdown_flag};
            end else begin
                s_nxt.rdata = 32'h0000_0000;
            end
        end
        // Writes land only on the edge that shows waitrequest low, so
        // the master sees them at its answer edge; writes land in sleep too
        if (avs_write_i && !avs_waitrequest_o) begin
            if (reg_hit[0]) begin
                s_nxt.ctrl = avs_writedata_i[7:0]
                             & pwr_ctrl_pkg::CONTROL_REGISTER_ZERO_MASK;
            end else if (reg_hit[1]) begin
                s_nxt.wake_en = avs_writedata_i[6:0];
            end else if (reg_hit[2]) begin
                s_nxt.adc_cfg = avs_writedata_i[3:0];
            end
        end
        // Watchdog clear instructions drop the power-down flag
        if (wdt_clear_i) begin
            s_nxt.powerdown_flag = 1'b0; // [R14]
        end
        case (s_r.mode)
            RUN: begin
                // Only the halt instruction enters sleep
                if (halt_exec_i) begin
                    s_nxt.mode      = SLEEP; // [R7]
                    s_nxt.powerdown_flag       = 1'b1; // [R10] [R14]
                    s_nxt.tof       = 1'b0; // [R10]
                    s_nxt.wclr      = 1'b1; // [R9]
                    s_nxt.cnt       = '0; // [R22]
                    s_nxt.irq_block = irq_req_i; // [R19]
                end
            end
            SLEEP: begin
                // Reset wins over the other wake sources
                if (ext_reset_i) begin
                    s_nxt.full_rst = 1'b1; // [R13]
                    s_nxt.mode     = RUN;
                end else if (wdt_overflow_i) begin
                    s_nxt.tof  = 1'b1; // [R15]
                    s_nxt.why  = WHY_WDT; // [R13]
                    s_nxt.mode = RESTART; // [R12]
                end else if (irq_wake) begin
                    s_nxt.why  = (irq_enabled_i && !stack_full_i)
                                 ? WHY_IRQ : WHY_RESUME; // [R17] [R18]
                    s_nxt.mode = RESTART; // [R12]
                end else if (pin_fall) begin
                    s_nxt.why  = WHY_RESUME; // [R16]
                    s_nxt.mode = RESTART; // [R12]
                end
            end
            RESTART: begin
                // Count only once the oscillator is running again
                if (ext_reset_i) begin
                    s_nxt.full_rst = 1'b1;
                    s_nxt.mode     = RUN;
                end else if (osc_ready_i) begin
                    s_nxt.cnt = s_r.cnt + 1'b1; // [R22]
                    if (s_r.cnt == LAST) begin
                        s_nxt.pcsp_rst = s_r.why == WHY_WDT; // [R15]
                        s_nxt.mode = (s_r.why == WHY_IRQ)
                                     ? IRQ_GAP : RUN; // [R20] [R21]
                    end
                end
            end
            IRQ_GAP: begin
                // One extra cycle before vectoring to the handler
                s_nxt.irq_go = 1'b1; // [R18] [R21]
                s_nxt.mode   = RUN;
            end
            default: begin
                s_nxt.mode = RUN;
            end
        endcase
    end

    // State register; power-up clears quick-start and both flags
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_r         <= '0;
            s_r.mode    <= RUN;
            s_r.ctrl    <= pwr_ctrl_pkg::CONTROL_REGISTER_ZERO_RESET; // [R3] [R14]
            s_r.pa_s1   <= 7'h7f;
            s_r.pa_s2   <= 7'h7f;
            s_r.pa_old  <= 7'h7f;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Output flops load the same next state as the state register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rc_osc_en_o             <= 1'b1;
            rtc_osc_en_o            <= 1'b1;
            rtc_quick_o             <= 1'b1;
            sysclk_rtc_o            <= 1'b0;
            sysclk_run_o            <= 1'b1;
            wdt_osc_en_o            <= WDT_OSC_ENABLE;
            wdt_clear_o             <= 1'b0;
            wdt_run_o               <= 1'b1;
            adc_power_o             <= 1'b0;
            hold_state_o            <= 1'b0;
            core_run_o              <= 1'b1;
            full_reset_o            <= 1'b0;
            pc_sp_reset_o           <= 1'b0;
            irq_service_o           <= 1'b0;
            powerdown_flag_o        <= 1'b0;
            watchdog_timeout_flag_o <= 1'b0;
            avs_readdata_o          <= 32'h0000_0000;
            avs_waitrequest_o       <= 1'b1;
        end else begin
            // RC off when RTC drives the system or in sleep; with RC selected it runs
            // during restart, else the restart count could never start
            rc_osc_en_o  <= !s_nxt.ctrl[pwr_ctrl_pkg::CLKSEL_BIT]
                            && s_nxt.mode != SLEEP; // [R1] [R2]
            rtc_osc_en_o <= 1'b1; // [R2] [R5]
            rtc_quick_o  <= !s_nxt.ctrl[pwr_ctrl_pkg::QSTART_BIT]; // [R5]
            sysclk_rtc_o <= s_nxt.ctrl[pwr_ctrl_pkg::CLKSEL_BIT]; // [R1]
            sysclk_run_o <= s_nxt.mode != SLEEP; // [R2]
            wdt_osc_en_o <= WDT_OSC_ENABLE; // [R6]
            wdt_clear_o  <= s_nxt.wclr; // [R9]
            wdt_run_o    <= !(WDT_FROM_SYS && s_nxt.mode != RUN); // [R9]
            adc_power_o  <= s_nxt.adc_cfg != pwr_ctrl_pkg::AN_NONE; // [R11]
            hold_state_o <= s_nxt.mode != RUN; // [R8]
            core_run_o   <= s_nxt.mode == RUN; // [R20]
            full_reset_o <= s_nxt.full_rst; // [R13]
            pc_sp_reset_o <= s_nxt.pcsp_rst; // [R15]
            irq_service_o <= s_nxt.irq_go; // [R18]
            powerdown_flag_o        <= s_nxt.powerdown_flag;
            watchdog_timeout_flag_o <= s_nxt.tof;
            avs_readdata_o    <= s_nxt.rdata;
            avs_waitrequest_o <= !((avs_read_i && !s_r.rd_done)
                                   || (avs_write_i && avs_waitrequest_o));
        end
    end

    // Halt raises the power-down flag and drops time-out at the next edge
    halt_sets_pdf_a: assert property ( // [R10]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == RUN && halt_exec_i)
        |=> powerdown_flag_o && !watchdog_timeout_flag_o)
        else $error("halt did not set power-down flag");

    // System clock is stopped while asleep
    sleep_clk_off_a: assert property ( // [R2]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        s_r.mode == SLEEP |-> !sysclk_run_o && !rc_osc_en_o)
        else $error("system clock ran in sleep");

    // Restart count starts from zero on every wake
    restart_len_a: assert property ( // [R22]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == RESTART && $past(s_r.mode) == SLEEP)
        |-> s_r.cnt == '0)
        else $error("restart counter not cleared");

    // Interrupt wake inserts the extra gap cycle before service
    irq_gap_a: assert property ( // [R21]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        s_r.mode == IRQ_GAP |=> s_r.mode == RUN && irq_service_o)
        else $error("interrupt gap missing");

    // Leaving restart other than by reset needs the full count
    restart_done_a: assert property ( // [R20]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == RESTART && s_nxt.mode != RESTART && !ext_reset_i)
        |-> s_r.cnt == LAST)
        else $error("restart ended early");

    // Watchdog wake sets the time-out flag
    wdt_wake_a: assert property ( // [R15]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == SLEEP && !ext_reset_i && wdt_overflow_i)
        |=> ##1 watchdog_timeout_flag_o)
        else $error("watchdog wake lost time-out flag");

    // Pending request from before halt cannot wake
    stale_irq_a: assert property ( // [R19]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == SLEEP && s_r.irq_block && !ext_reset_i
         && !wdt_overflow_i && !pin_fall) |=> s_r.mode == SLEEP)
        else $error("stale interrupt woke device");

    // External reset in sleep gives a full reset pulse
    reset_wake_a: assert property ( // [R13]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == SLEEP && ext_reset_i) |=> full_reset_o)
        else $error("reset wake without full reset");

    // Clock select steers the system source
    clk_sel_a: assert property ( // [R1]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        s_r.ctrl[pwr_ctrl_pkg::CLKSEL_BIT]
        |=> sysclk_rtc_o || $past(avs_write_i))
        else $error("clock select not followed");

    // Analog configuration keeps the converter powered
    adc_on_a: assert property ( // [R11]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.adc_cfg != pwr_ctrl_pkg::AN_NONE && !avs_write_i)
        |=> adc_power_o)
        else $error("converter powered down");

    // The select bit keeps the RC oscillator off
    rc_off_rtc_a: assert property ( // [R1]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        s_r.ctrl[pwr_ctrl_pkg::CLKSEL_BIT] |-> !rc_osc_en_o)
        else $error("RC oscillator on with RTC selected");

    // Nothing but halt moves a running core into sleep
    halt_only_a: assert property ( // [R7]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == RUN && !halt_exec_i) |=> s_r.mode != SLEEP)
        else $error("sleep entered without halt");

    // Halt pulses the watchdog clear
    halt_wdt_clr_a: assert property ( // [R9]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == RUN && halt_exec_i) |=> wdt_clear_o)
        else $error("halt did not clear watchdog");

    // Sleep holds state and keeps the core stopped
    sleep_hold_a: assert property ( // [R8]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        s_r.mode == SLEEP |-> hold_state_o && !core_run_o)
        else $error("state not held in sleep");

    // Clear-watchdog without halt drops the power-down flag
    pdf_clear_a: assert property ( // [R14]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (wdt_clear_i && !(s_r.mode == RUN && halt_exec_i))
        |=> !powerdown_flag_o)
        else $error("power-down flag not cleared");

    // A lone pin edge wakes into a plain resume
    pin_wake_a: assert property ( // [R16]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == SLEEP && pin_fall && !ext_reset_i
         && !wdt_overflow_i && !irq_wake)
        |=> s_r.mode == RESTART && s_r.why == WHY_RESUME)
        else $error("pin wake missed");

    // Watchdog wake resets only program counter and stack at the end
    wdt_pcsp_a: assert property ( // [R15]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_r.mode == RESTART && s_r.why == WHY_WDT && osc_ready_i
         && s_r.cnt == LAST && !ext_reset_i)
        |=> pc_sp_reset_o && !full_reset_o)
        else $error("watchdog wake reset missing");

    // Service never starts unless the gap cycle went before it
    svc_after_gap_a: assert property ( // [R21]
        @(posedge sys_clk_i) disable iff (!nrst_i)
        irq_service_o |-> $past(s_r.mode) == IRQ_GAP)
        else $error("service without gap");
endmodule // power_down_wakeup_clock_select

// ---- verif/osc_model.sv ----
`timescale 1ns/1ns
module osc_model #(
    parameter int START = 6
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic en_i,
    output logic      ready_o
);
    logic [3:0] cnt_r;
    // A real oscillator needs time to settle, so ready lags the enable
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) cnt_r <= 4'h0;
        else if (!en_i) cnt_r <= 4'h0;
        else if (cnt_r < 4'(START)) cnt_r <= cnt_r + 4'h1;
    end
    assign ready_o = (cnt_r == 4'(START)); // Drops on the next clock edge after disable
endmodule // osc_model

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
    logic        sys_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0, wr = 1'b0, wrq, ordy;
    logic [31:0] wd = 32'h0000_0000, rdat;
    logic        halt = 0, wclr = 0, xrst = 0, wov = 0;
    logic        irq = 0, ien = 0, sfull = 0;
    logic [6:0]  pa = 7'h7f;
    logic        rc_en, rtc_en, quick, rtc_sel, clk_run, osc_w, clr_o;
    logic        run_w, adcp, hold, crun, frst, pcsp, isvc, pd_f, tout_f;
    logic [3:0]  seen = 4'h0;
    logic [31:0] exp_q[$];
    int          num_errors = 0, samples_checked = 0, k, n;
    always #10 sys_clk_i = ~sys_clk_i;
    power_down_wakeup_clock_select u_power_down_wakeup_clock_select (
        .sys_clk_i, .nrst_i, .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wrq), .halt_exec_i(halt), .wdt_clear_i(wclr),
        .ext_reset_i(xrst), .wdt_overflow_i(wov), .irq_req_i(irq),
        .irq_enabled_i(ien), .stack_full_i(sfull), .port_a_i(pa),
        .osc_ready_i(ordy), .rc_osc_en_o(rc_en), .rtc_osc_en_o(rtc_en),
        .rtc_quick_o(quick), .sysclk_rtc_o(rtc_sel), .sysclk_run_o(clk_run),
        .wdt_osc_en_o(osc_w), .wdt_clear_o(clr_o), .wdt_run_o(run_w),
        .adc_power_o(adcp), .hold_state_o(hold), .core_run_o(crun),
        .full_reset_o(frst), .pc_sp_reset_o(pcsp), .irq_service_o(isvc),
        .powerdown_flag_o(pd_f), .watchdog_timeout_flag_o(tout_f));
    osc_model u_osc_model (.clk_i(sys_clk_i), .nrst_i,
        .en_i(rc_en | rtc_sel), .ready_o(ordy));
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bad(input string m);
        num_errors++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk(input logic a, input logic e, input string m);
        samples_checked++;
        if (a !== e) bad(m);
    endtask
    // Single-cycle pulses are latched so a check cannot miss them
    always @(posedge sys_clk_i) begin
        if (frst === 1'b1) seen[0] <= 1'b1;
        if (pcsp === 1'b1) seen[1] <= 1'b1;
        if (isvc === 1'b1) seen[2] <= 1'b1;
        if (clr_o === 1'b1) seen[3] <= 1'b1;
    end
    // Scoreboard: oldest expected word meets each completed read
    always @(posedge sys_clk_i) begin
        if (rd === 1'b1 && wrq === 1'b0) begin
            samples_checked++;
            if (exp_q.size() == 0 || rdat !== exp_q[0]) bad("read data");
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int c;
        @(posedge sys_clk_i);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        c = 0;
        do begin
            @(posedge sys_clk_i);
            c++;
        end while (wrq !== 1'b0 && c < 50);
        if (c >= 50) bad("no answer");
        if (c >= 50) results();
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdx(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge sys_clk_i);
    endtask
    task automatic wait_run();
        n = 0;
        while (crun !== 1'b1 && n < 1300) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 1300) bad("no resume");
        if (n >= 1300) results();
    endtask
    // Halt, then check the sleeping state three edges after halt is sampled
    task automatic sleep();
        @(posedge sys_clk_i);
        halt <= 1'b1;
        seen <= 4'h0;
        @(posedge sys_clk_i);
        halt <= 1'b0;
        settle(3);
        chk(clk_run | crun, 1'b0, "clock runs in sleep");
        chk(pd_f & ~tout_f & rtc_en, 1'b1, "halt flags");
        chk(hold & osc_w & run_w, 1'b1, "sleep state");
        chk(seen[3] & ~rc_en, 1'b1, "halt clears watchdog");
    endtask
    initial begin
        k = $urandom(24489);
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        settle(1);
        chk(quick & rc_en & ~rtc_sel, 1'b1, "reset clocking");
        rdx(pwr_ctrl_pkg::OFF_CONTROL_REGISTER_ZERO, 32'h0000_0000);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        rdx(4'h2, 32'h0000_0000);
        bus(1'b1, pwr_ctrl_pkg::OFF_CONTROL_REGISTER_ZERO, 32'h0000_0003);
        settle(2);
        chk(rtc_sel & ~rc_en & rtc_en & ~quick, 1'b1, "rtc clock");
        k = $urandom;
        bus(1'b1, pwr_ctrl_pkg::OFF_CONTROL_REGISTER_ZERO, k);
        rdx(pwr_ctrl_pkg::OFF_CONTROL_REGISTER_ZERO, k & 32'(pwr_ctrl_pkg::CONTROL_REGISTER_ZERO_MASK));
        bus(1'b1, pwr_ctrl_pkg::OFF_CONTROL_REGISTER_ZERO, 32'h0000_0002);
        bus(1'b1, pwr_ctrl_pkg::OFF_ADC_CFG, 32'h0000_0005);
        $display("test registers done");
        k = $urandom % 7;
        bus(1'b1, pwr_ctrl_pkg::OFF_WAKE_EN, 32'h0000_0001 << k);
        sleep();
        chk(adcp, 1'b1, "adc kept on");
        pa <= ~(7'h01 << ((k + 1) % 7));
        settle(40);
        chk(crun, 1'b0, "disabled pin woke");
        pa <= 7'h7f & ~(7'h01 << k);
        wait_run();
        chk(n >= 1024 && n <= 1060, 1'b1, "pin restart delay");
        chk(seen[2:0] == 3'h0, 1'b1, "pin wake resumes");
        pa <= 7'h7f;
        rdx(pwr_ctrl_pkg::OFF_CONTROL_REGISTER_ZERO, 32'h0000_0002);
        rdx(pwr_ctrl_pkg::OFF_STATUS, 32'h0000_0001);
        @(posedge sys_clk_i);
        wclr <= 1'b1;
        @(posedge sys_clk_i);
        wclr <= 1'b0;
        rdx(pwr_ctrl_pkg::OFF_STATUS, 32'h0000_0000);
        bus(1'b1, pwr_ctrl_pkg::OFF_ADC_CFG, 32'h0000_0000);
        settle(2);
        chk(adcp, 1'b0, "adc off");
        $display("test pin wake done");
        // Interrupt cases: serviced, disabled, stack full
        for (int i = 0; i < 3; i++) begin
            ien <= (i != 1);
            sfull <= (i == 2);
            irq <= 1'b1;
            sleep();
            settle(40);
            chk(crun, 1'b0, "stale request woke");
            irq <= 1'b0;
            settle(3);
            irq <= 1'b1;
            wait_run();
            chk(n >= 1024 && seen[2] === 1'b0, 1'b1, "irq delay");
            settle(4);
            chk(seen[2], i == 0, "irq service");
            irq <= 1'b0;
        end
        $display("test interrupt wake done");
        sleep();
        wov <= 1'b1;
        @(posedge sys_clk_i);
        wov <= 1'b0;
        wait_run();
        settle(3);
        chk(tout_f & seen[1] & ~seen[0], 1'b1, "watchdog wake");
        sleep();
        xrst <= 1'b1;
        @(posedge sys_clk_i);
        xrst <= 1'b0;
        settle(4);
        chk(seen[0] & crun, 1'b1, "reset wake");
        $display("test reset wake done");
        results();
    end
endmodule // tb
